// File: inc/loader_pkg.sv
// Shared constants and types of the configuration image loader
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package loader_pkg;
  // Image geometry
  localparam int IMG_BYTES = 1024;
  localparam logic [9:0] HDR_ADDR = 10'h000;
  localparam logic [9:0] HDR_LEN = 10'h003;
  // First map entry address byte; the byte before it is the header check
  localparam logic [9:0] MAP_BASE = 10'h004;
  localparam logic [9:0] BLK_LEN = 10'h025;
  localparam logic [9:0] STRIDE_SMALL = 10'h002;
  localparam logic [9:0] STRIDE_BIG = 10'h003;
  // Header byte zero fields
  localparam int HDR_CRC_POS = 7;
  localparam int HDR_MAP_POS = 6;
  localparam int HDR_BIG_POS = 5;
  localparam int HDR_CNT_LSB = 0;
  // Block byte offsets
  localparam logic [5:0] BLK_FIRST = 6'h03;
  localparam logic [5:0] BLK_LAST = 6'h27;
  // Fixed check pattern
  localparam logic [7:0] CRC_FIXED = 8'ha5;
  // Register file
  localparam int REG_COUNT = 96;
  localparam logic [7:0] REG_LAST = 8'h5f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] OBS_ADDR = 8'h00;
  localparam int OBS_DONE_POS = 2;
  localparam int OBS_AD_LSB = 3;
  localparam logic [7:0] CHECK_ADDR = 8'h7e;
  localparam logic [7:0] CTRL_ADDR = 8'h7f;
  localparam int CTRL_RESTART_POS = 0;
  localparam int CTRL_BUSY_POS = 0;
  localparam int CTRL_SKIP_POS = 1;
  localparam int CTRL_ERR_POS = 2;
  // Loader sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_MAP_HI = 3'b010,
    ST_MAP_LO = 3'b011,
    ST_MAP_CRC = 3'b100,
    ST_BLK_RD = 3'b101,
    ST_BLK_BITS = 3'b110,
    ST_DONE = 3'b111
  } load_state_t;
endpackage

// File: rtl/image_byte_reader.sv
// Single-byte fetch handshake toward the image memory
module image_byte_reader (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fetch,
  input wire logic [9:0] fetch_addr,
  input wire logic rom_ack,
  input wire logic [7:0] rom_data,
  output logic rom_req,
  output logic [9:0] rom_addr,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // All reader state
  typedef struct packed {
    logic req;
    logic [9:0] addr;
    logic valid;
    logic [7:0] data;
  } rd_state_t;
  rd_state_t s_reg; // Registered state
  rd_state_t s_next; // Next state

  // Hold request until answered, then pulse valid
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    if (!s_reg.req && fetch) begin
      s_next.req = 1'b1;
      s_next.addr = fetch_addr;
    end else if (s_reg.req && rom_ack) begin
      s_next.req = 1'b0;
      s_next.valid = 1'b1;
      s_next.data = rom_data;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rom_req = s_reg.req;
  assign rom_addr = s_reg.addr;
  assign byte_valid = s_reg.valid;
  assign byte_data = s_reg.data;
endmodule

// File: rtl/bit_route_table.sv
// Target register and bit for each bit of a device block
module bit_route_table (
  input wire logic [5:0] byte_off,
  input wire logic [2:0] bit_idx,
  output logic [6:0] reg_idx,
  output logic [2:0] reg_bit
);
  // One row per block byte, bit 7 entry first, each {reg, bit}
  function automatic logic [127:0] route_row(input logic [5:0] off);
    logic [127:0] r;
    r = '0;
    unique case (off)
      6'h03: r = 128'h01070106010501040103010201010100;
      6'h04: r = 128'h02050204020302020200040704060405;
      6'h05: r = 128'h04040403040204010400060408060805;
      6'h06: r = 128'h080408030802080108000b060b050b04;
      6'h07: r = 128'h0b030b020b010b000e050e040e030e02;
      6'h08: r = 128'h0f070f060f050f040f030f020f010f00;
      6'h09: r = 128'h10071006100510041003100210011000;
      6'h0a: r = 128'h11021101110012071203120212011200;
      6'h0b: r = 128'h15051504150315021607160616051604;
      6'h0c: r = 128'h16031602160116001707170617051704;
      6'h0d: r = 128'h17031702170117001802180118001907;
      6'h0e: r = 128'h19031902190119001c051c041c031c02;
      6'h0f: r = 128'h1d071d061d051d041d031d021d011d00;
      6'h10: r = 128'h1e071e061e051e041e031e021e011e00;
      6'h11: r = 128'h1f021f011f0020072003200220012000;
      6'h12: r = 128'h23052304230323022407240624052404;
      6'h13: r = 128'h24032402240124002507250625052504;
      6'h14: r = 128'h25032502250125002602260126002707;
      6'h15: r = 128'h27032702270127002806280528042803;
      6'h16: r = 128'h2802280128002b052b042b032b022c07;
      6'h17: r = 128'h2c062c052c042c032c022c012c002d07;
      6'h18: r = 128'h2d062d052d042d032d022d012d002e02;
      6'h19: r = 128'h2e012e002f072f032f022f012f003205;
      6'h1a: r = 128'h32043203320233073306330533043303;
      6'h1b: r = 128'h33023301330034073406340534043403;
      6'h1c: r = 128'h34023401340035023501350036073603;
      6'h1d: r = 128'h36023601360039053904390339023a07;
      6'h1e: r = 128'h3a063a053a043a033a023a013a003b07;
      6'h1f: r = 128'h3b063b053b043b033b023b013b003c02;
      6'h20: r = 128'h3c013c003d073d033d023d013d004005;
      6'h21: r = 128'h40044003400241074106410541044103;
      6'h22: r = 128'h41024101410042074206420542044203;
      6'h23: r = 128'h42024201420043024301430044074403;
      6'h24: r = 128'h44024401440047034702470147004807;
      6'h25: r = 128'h48064c074c064c054c044c034c005900;
      6'h26: r = 128'h5a075a065a055a045a035a025a015a00;
      6'h27: r = 128'h5b075b065b055b045b035b025b015b00;
      default: r = '0;
    endcase
    return r;
  endfunction

  logic [127:0] row; // Whole row of the current block byte
  logic [15:0] entry; // Selected {reg, bit} entry

  // Pick the entry of the requested bit
  always_comb begin
    row = route_row(byte_off);
    entry = row[{bit_idx, 4'h0} +: 16];
    reg_idx = entry[14:8];
    reg_bit = entry[2:0];
  end
endmodule

// File: rtl/eeprom_config_image_loader.sv
// Power-up loader copying one device block into control registers
//
// The address map and the address-and-strobe port were decided locally.
module eeprom_config_image_loader (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] dev_index,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rom_ack,
  input wire logic [7:0] rom_data,
  output logic rom_req,
  output logic [9:0] rom_addr,
  output logic load_done
);
  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    loader_pkg::load_state_t st;
    logic pend; // Fetch outstanding
    logic crc_en; // Header check flag
    logic map_on; // Header map flag
    logic big; // Header large image flag
    logic [3:0] count; // Devices minus one
    logic [9:0] ptr; // Next image address
    logic [7:0] hi; // Upper address byte
    logic [5:0] off; // Block byte offset
    logic [2:0] bit_i; // Bit being applied
    logic [7:0] cur; // Block byte in work
    logic done; // Load complete
    logic skip; // No block for this device
    logic err; // Block beyond image end
    logic [7:0] check; // Check byte in force
    logic [7:0] rdata; // Read answer
    logic [loader_pkg::REG_COUNT-1:0][7:0] regs; // Control registers
  } top_state_t;

  top_state_t s_reg; // Registered state
  top_state_t s_next; // Next state

  logic fetch; // Start a byte fetch
  logic byte_valid; // Fetched byte present
  logic [7:0] byte_data; // Fetched byte
  logic [6:0] route_idx; // Target register
  logic [2:0] route_bit; // Target bit

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // True when a whole block at this start lies inside the image
  function automatic logic blk_fits(input logic [9:0] start);
    logic [10:0] last;
    last = 11'(start) + 11'(loader_pkg::BLK_LEN) - 11'h001;
    return last < 11'(loader_pkg::IMG_BYTES);
  endfunction

  // Offset of a map entry for one device
  function automatic logic [9:0] map_entry(
    input logic [3:0] dev,
    input logic big
  );
    logic [9:0] stride;
    stride = big ? loader_pkg::STRIDE_BIG : loader_pkg::STRIDE_SMALL;
    return loader_pkg::MAP_BASE + 10'(dev) * stride;
  endfunction

  //--------------------------------------------------------------------
  // Submodules
  //--------------------------------------------------------------------
  // Image byte fetch handshake
  image_byte_reader u_reader (
    .mclk(mclk),
    .rst_n(rst_n),
    .fetch(fetch),
    .fetch_addr(s_reg.ptr),
    .rom_ack(rom_ack),
    .rom_data(rom_data),
    .rom_req(rom_req),
    .rom_addr(rom_addr),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  // Scatter table lookup
  bit_route_table u_route (
    .byte_off(s_reg.off),
    .bit_idx(s_reg.bit_i),
    .reg_idx(route_idx),
    .reg_bit(route_bit)
  );

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    logic [9:0] blk;
    blk = '0;
    s_next = s_reg;
    fetch = 1'b0;
    s_next.rdata = 8'h00;

    // Software register write
    if (reg_wr && reg_addr <= loader_pkg::REG_LAST) begin
      s_next.regs[reg_addr[6:0]] = reg_wdata;
    end

    // Software register read, answered next cycle
    if (reg_rd) begin
      if (reg_addr == loader_pkg::OBS_ADDR) begin
        s_next.rdata = s_reg.regs[0];
        s_next.rdata[6:loader_pkg::OBS_AD_LSB] = dev_index;
        s_next.rdata[loader_pkg::OBS_DONE_POS] = s_reg.done;
      end else if (reg_addr <= loader_pkg::REG_LAST) begin
        s_next.rdata = s_reg.regs[reg_addr[6:0]];
      end else if (reg_addr == loader_pkg::CHECK_ADDR) begin
        s_next.rdata = s_reg.check;
      end else if (reg_addr == loader_pkg::CTRL_ADDR) begin
        s_next.rdata[loader_pkg::CTRL_BUSY_POS] = !s_reg.done;
        s_next.rdata[loader_pkg::CTRL_SKIP_POS] = s_reg.skip;
        s_next.rdata[loader_pkg::CTRL_ERR_POS] = s_reg.err;
      end else begin
        s_next.rdata = 8'h00;
      end
    end

    // Loader sequence
    unique case (s_reg.st)
      // Leave reset and start reading the header
      loader_pkg::ST_IDLE: begin
        s_next.ptr = loader_pkg::HDR_ADDR;
        s_next.st = loader_pkg::ST_HDR;
      end

      // Header byte zero
      loader_pkg::ST_HDR: begin
        if (!s_reg.pend) begin
          fetch = 1'b1;
          s_next.pend = 1'b1;
        end else if (byte_valid) begin
          s_next.pend = 1'b0;
          s_next.crc_en = byte_data[loader_pkg::HDR_CRC_POS];
          s_next.map_on = byte_data[loader_pkg::HDR_MAP_POS];
          s_next.big = byte_data[loader_pkg::HDR_BIG_POS];
          s_next.count = byte_data[loader_pkg::HDR_CNT_LSB +: 4];
          s_next.check = loader_pkg::CRC_FIXED;
          if (dev_index > byte_data[loader_pkg::HDR_CNT_LSB +: 4]) begin
            // Image holds no block for this device
            s_next.skip = 1'b1;
            s_next.done = 1'b1;
            s_next.st = loader_pkg::ST_DONE;
          end else if (byte_data[loader_pkg::HDR_MAP_POS]) begin
            // Walk to this device's map entry
            s_next.ptr = map_entry(dev_index,
              byte_data[loader_pkg::HDR_BIG_POS]);
            s_next.st = byte_data[loader_pkg::HDR_BIG_POS] ?
              loader_pkg::ST_MAP_HI : loader_pkg::ST_MAP_LO;
          end else begin
            // Blocks packed right after the header
            blk = loader_pkg::HDR_LEN
              + 10'(dev_index) * loader_pkg::BLK_LEN;
            s_next.ptr = blk;
            s_next.off = loader_pkg::BLK_FIRST;
            if (blk_fits(blk)) begin
              s_next.st = loader_pkg::ST_BLK_RD;
            end else begin
              s_next.err = 1'b1;
              s_next.done = 1'b1;
              s_next.st = loader_pkg::ST_DONE;
            end
          end
        end
      end

      // Upper start address byte of a large image
      loader_pkg::ST_MAP_HI: begin
        if (!s_reg.pend) begin
          fetch = 1'b1;
          s_next.pend = 1'b1;
        end else if (byte_valid) begin
          s_next.pend = 1'b0;
          s_next.hi = byte_data;
          s_next.ptr = s_reg.ptr + 10'h001;
          s_next.st = loader_pkg::ST_MAP_LO;
        end
      end

      // Lower start address byte
      loader_pkg::ST_MAP_LO: begin
        if (!s_reg.pend) begin
          fetch = 1'b1;
          s_next.pend = 1'b1;
        end else if (byte_valid) begin
          s_next.pend = 1'b0;
          s_next.ptr = s_reg.ptr + 10'h001;
          // Shared start addresses need nothing special
          s_next.hi = s_reg.big ? s_reg.hi : 8'h00;
          s_next.cur = byte_data;
          if (s_reg.big && s_reg.hi[7:2] != 6'h00) begin
            s_next.err = 1'b1;
            s_next.done = 1'b1;
            s_next.st = loader_pkg::ST_DONE;
          end else begin
            s_next.st = loader_pkg::ST_MAP_CRC;
          end
        end
      end

      // Entry check byte; ignored as a check while disabled
      loader_pkg::ST_MAP_CRC: begin
        if (!s_reg.pend) begin
          fetch = 1'b1;
          s_next.pend = 1'b1;
        end else if (byte_valid) begin
          s_next.pend = 1'b0;
          s_next.check = s_reg.crc_en ?
            byte_data : loader_pkg::CRC_FIXED;
          blk = {s_reg.hi[1:0], s_reg.cur};
          s_next.ptr = blk;
          s_next.off = loader_pkg::BLK_FIRST;
          if (blk_fits(blk)) begin
            s_next.st = loader_pkg::ST_BLK_RD;
          end else begin
            s_next.err = 1'b1;
            s_next.done = 1'b1;
            s_next.st = loader_pkg::ST_DONE;
          end
        end
      end

      // Fetch the next block byte
      loader_pkg::ST_BLK_RD: begin
        if (!s_reg.pend) begin
          fetch = 1'b1;
          s_next.pend = 1'b1;
        end else if (byte_valid) begin
          s_next.pend = 1'b0;
          s_next.cur = byte_data;
          s_next.bit_i = 3'h7;
          s_next.st = loader_pkg::ST_BLK_BITS;
        end
      end

      // Apply one bit per cycle, reserved bits included
      loader_pkg::ST_BLK_BITS: begin
        s_next.regs[route_idx][route_bit] =
          s_reg.cur[s_reg.bit_i];
        if (s_reg.bit_i != 3'h0) begin
          s_next.bit_i = s_reg.bit_i - 3'h1;
        end else if (s_reg.off == loader_pkg::BLK_LAST) begin
          // Last bit of the block written this cycle
          s_next.done = 1'b1;
          s_next.st = loader_pkg::ST_DONE;
        end else begin
          // Consecutive image bytes
          s_next.off = s_reg.off + 6'h01;
          s_next.ptr = s_reg.ptr + 10'h001;
          s_next.st = loader_pkg::ST_BLK_RD;
        end
      end

      // Loaded; a software restart runs it again
      loader_pkg::ST_DONE: begin
        if (reg_wr && reg_addr == loader_pkg::CTRL_ADDR
            && reg_wdata[loader_pkg::CTRL_RESTART_POS]) begin
          s_next.done = 1'b0;
          s_next.skip = 1'b0;
          s_next.err = 1'b0;
          s_next.ptr = loader_pkg::HDR_ADDR;
          s_next.st = loader_pkg::ST_HDR;
        end
      end
    endcase
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.st <= loader_pkg::ST_IDLE;
      s_reg.pend <= 1'b0;
      s_reg.crc_en <= 1'b0;
      s_reg.map_on <= 1'b0;
      s_reg.big <= 1'b0;
      s_reg.count <= 4'h0;
      s_reg.ptr <= 10'h000;
      s_reg.hi <= 8'h00;
      s_reg.off <= 6'h00;
      s_reg.bit_i <= 3'h0;
      s_reg.cur <= 8'h00;
      s_reg.done <= 1'b0;
      s_reg.skip <= 1'b0;
      s_reg.err <= 1'b0;
      s_reg.check <= 8'h00;
      s_reg.rdata <= 8'h00;
      s_reg.regs <= {loader_pkg::REG_COUNT{loader_pkg::REG_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = s_reg.rdata;
  assign load_done = s_reg.done;
endmodule

// File: dv/loader_assertions.sv
// Port-level assertions of the configuration image loader
module loader_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] dev_index,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rom_ack,
  input wire logic [7:0] rom_data,
  input wire logic rom_req,
  input wire logic [9:0] rom_addr,
  input wire logic load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks on the rising clock, quiet while reset is low
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Header byte is the first fetch after reset
  a_first_fetch: assert property (
    $rose(rst_n) |-> ##[1:3] (rom_req && rom_addr == 10'h000))
    else $error("header fetch missing after reset");
  // A pending fetch keeps its address until answered
  a_req_stable: assert property (
    rom_req && !rom_ack |=> rom_req && $stable(rom_addr))
    else $error("fetch dropped or address moved before answer");
  // One byte per answer: request falls right after it
  a_req_release: assert property (
    rom_req && rom_ack |=> !rom_req)
    else $error("fetch still raised after answer");
  // Completion stays up unless software restarts
  a_done_sticky: assert property (
    load_done && !(reg_wr && reg_addr == 8'h7f) |=> load_done)
    else $error("completion flag fell on its own");
  // No fetch once loading is complete
  a_done_quiet: assert property (
    load_done |-> !rom_req)
    else $error("fetch raised after completion");
  // A fresh byte is never followed at once by completion
  a_done_gap: assert property (
    rom_req && rom_ack |=> !load_done)
    else $error("completion before last byte was applied");
  // Read data is zero outside the answer cycle
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  // Observation register shows position and completion
  a_obs_fields: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h00 |->
      reg_rdata[6:2] == {$past(dev_index), $past(load_done)})
    else $error("observation fields wrong");
endmodule

bind eeprom_config_image_loader loader_assertions i_loader_assertions (
  .mclk(mclk), .rst_n(rst_n), .dev_index(dev_index),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_ack(rom_ack),
  .rom_data(rom_data), .rom_req(rom_req), .rom_addr(rom_addr),
  .load_done(load_done)
);

// File: dv/image_rom_model.sv
// Behavioural image memory answering the loader's byte fetches
module image_rom_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rom_req,
  input wire logic [9:0] rom_addr,
  input wire logic [3:0] latency,
  output logic rom_ack,
  output logic [7:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [1024];  // Whole image, never larger
  logic [3:0] wait_cnt;  // Cycles spent on the pending fetch
  // Answer after the set latency, one pulse per fetch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rom_ack <= 1'b0;
      rom_data <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (rom_ack) begin
      // Byte no longer held: show its inverse
      rom_ack <= 1'b0;
      rom_data <= ~rom_data;
      wait_cnt <= 4'h0;
    end else if (rom_req && wait_cnt >= latency) begin
      rom_ack <= 1'b1;
      rom_data <= mem[rom_addr];  // Byte at the asked offset
    end else if (rom_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      rom_data <= ~rom_data;  // Idle data keeps changing
    end
  end
endmodule

// File: dv/tb_eeprom_config_image_loader.sv
// Self-checking bench of the configuration image loader
module tb_eeprom_config_image_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, reg_wr, reg_rd, rom_ack, rom_req, load_done;
  logic [3:0] dev_index, rom_lat;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rom_data, rd_val, v, s;
  logic [9:0] rom_addr;
  logic [7:0] img [1024];  // Bench copy of the image
  int errors, n_checks;
  // Routes: register, block byte, source msb, source lsb, target lsb
  int route [20][5] = '{
    '{8'h1f, 8'h11, 7, 5, 0}, '{8'h20, 8'h11, 4, 4, 7},
    '{8'h20, 8'h11, 3, 0, 0}, '{8'h27, 8'h15, 7, 4, 0},
    '{8'h28, 8'h15, 3, 0, 3}, '{8'h28, 8'h16, 7, 5, 0},
    '{8'h2b, 8'h16, 4, 1, 2}, '{8'h2c, 8'h16, 0, 0, 7},
    '{8'h34, 8'h1c, 7, 5, 0}, '{8'h35, 8'h1c, 4, 2, 0},
    '{8'h36, 8'h1c, 1, 1, 7}, '{8'h36, 8'h1c, 0, 0, 3},
    '{8'h41, 8'h22, 6, 5, 0}, '{8'h42, 8'h22, 4, 4, 7},
    '{8'h48, 8'h25, 7, 7, 6}, '{8'h4c, 8'h25, 6, 2, 3},
    '{8'h4c, 8'h25, 1, 1, 0}, '{8'h59, 8'h25, 0, 0, 0},
    '{8'h5a, 8'h26, 7, 0, 0}, '{8'h5b, 8'h27, 7, 0, 0}};

  eeprom_config_image_loader i_eeprom_config_image_loader (
    .mclk(mclk), .rst_n(rst_n), .dev_index(dev_index),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_ack(rom_ack),
    .rom_data(rom_data), .rom_req(rom_req), .rom_addr(rom_addr),
    .load_done(load_done));
  image_rom_model i_image_rom_model (
    .mclk(mclk), .rst_n(rst_n), .rom_req(rom_req), .rom_addr(rom_addr),
    .latency(rom_lat), .rom_ack(rom_ack), .rom_data(rom_data));

  // Free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Mask of one route's field width
  function automatic logic [7:0] wmask(int k);
    return 8'((1 << (route[k][2] - route[k][3] + 1)) - 1);
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data taken in the answer cycle
  task automatic reg_read(logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  // Load the image, reset with a new position, wait for completion
  task automatic run_load(logic [3:0] dev);
    int i;
    for (i = 0; i < 1024; i++) i_image_rom_model.mem[i] = img[i];
    @(posedge mclk);
    rst_n <= 1'b0;
    dev_index <= dev;
    rom_lat <= 4'($urandom_range(3));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 3000 && load_done !== 1'b1; i++) @(posedge mclk);
    #1;
    check("load done", {7'h00, load_done}, 8'h01);
  endtask

  // Compare the 20 listed routed fields, the observation register and the check byte
  task automatic verify(logic [3:0] dev, int base, logic [7:0] crc);
    for (int k = 0; k < 20; k++) begin
      reg_read(8'(route[k][0]));
      v = (img[base + route[k][1] - 3] >> route[k][3]) & wmask(k);
      s = (rd_val >> route[k][4]) & wmask(k);
      check("routed field", s, v);
    end
    reg_read(8'h00);
    check("observation", rd_val, {1'b0, dev, 1'b1, 2'b00});
    reg_read(8'h7e);
    check("check byte", rd_val, crc);
  endtask

  task automatic results();
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    dev_index = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rom_lat = 4'h0;
    errors = 0;
    n_checks = 0;
    void'($urandom(22926));
    foreach (img[i]) img[i] = 8'($urandom);
    // Four devices, small map, pairs sharing one block
    img[0] = 8'h43;
    for (int d = 0; d < 4; d++) img[4+2*d] = d < 2 ? 8'h0b : 8'h30;
    for (int d = 0; d < 4; d++) begin
      run_load(4'(d));
      verify(4'(d), d < 2 ? 11 : 48, 8'ha5);
    end
    // Check enabled: entry's own check byte in force
    img[0] = 8'hc3;
    run_load(4'h1);
    verify(4'h1, 11, img[7]);
    // Position beyond the device count is skipped
    img[0] = 8'h43;
    run_load(4'h4);
    reg_read(8'h7f);
    check("skip status", rd_val, 8'h02);
    // No map: blocks follow the header back to back
    img[0] = 8'h03;
    run_load(4'h2);
    verify(4'h2, 77, 8'ha5);
    // Large image: three-byte entries, block ending on the last byte
    img[0] = 8'h63;
    img[7] = 8'h03;
    img[8] = 8'hdb;
    run_load(4'h1);
    verify(4'h1, 987, 8'ha5);
    // Block one byte past the image end
    img[8] = 8'hdc;
    run_load(4'h1);
    reg_read(8'h7f);
    check("overrun status", rd_val, 8'h04);
    // Mend the entry and restart by software without a reset
    img[8] = 8'hdb;
    i_image_rom_model.mem[8] = img[8];
    reg_write(8'h7f, 8'h01);
    @(posedge mclk);
    for (int i = 0; i < 3000 && load_done !== 1'b1; i++) @(posedge mclk);
    #1;
    check("restart done", {7'h00, load_done}, 8'h01);
    verify(4'h1, 987, 8'ha5);
    // Software access: plain register, read-only bits, unmapped
    v = 8'($urandom);
    reg_write(8'h5a, v);
    reg_read(8'h5a);
    check("written reg", rd_val, v);
    reg_write(8'h00, 8'hff);
    reg_read(8'h00);
    check("observation", rd_val, 8'h8f);
    reg_read(8'h60);
    check("unmapped", rd_val, 8'h00);
    results();
  end

  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end
endmodule
